// File: hw/clkc_cfg.svh
// register offsets, field positions, reset values of the control bank
// assumes byte-wide register port with byte addresses equal to offsets
`ifndef CLKC_CFG_SVH
`define CLKC_CFG_SVH

// ****************************************
// offsets
// ****************************************
`define CLKC_OFF_TEST_CTRL    8'h09
`define CLKC_OFF_MGMT_CPU     8'h0b
`define CLKC_OFF_BYTE_COUNT   8'h0c
`define CLKC_OFF_SLEW_A       8'h0d
`define CLKC_OFF_RSVD         8'h0e
`define CLKC_OFF_SREF_STOP    8'h11
`define CLKC_OFF_DIFF_A       8'h12
`define CLKC_OFF_DIFF_B       8'h13
`define CLKC_OFF_SLEW_B       8'h14
`define CLKC_OFF_SLEW_C       8'h15

// ****************************************
// field positions
// ****************************************
`define CLKC_POS_SW_SEL       4
`define CLKC_POS_SW_ENTRY     3
`define CLKC_POS_LP3_EN       3
`define CLKC_POS_LP2_EN       2
`define CLKC_POS_STOP3_EN     0
`define CLKC_POS_SLEW_REF     6
`define CLKC_POS_SLEW_FIX     4
`define CLKC_POS_SLEW_SS      2
`define CLKC_POS_SREF11_STOP  6
`define CLKC_POS_VOUT_SRC     3
`define CLKC_POS_VOUT_S2A     0
`define CLKC_POS_VOUT_LCD     5
`define CLKC_POS_VOUT_DOT     2

// ****************************************
// reset values and the high-impedance slew code
// ****************************************
`define CLKC_RST_LP3_EN       1'b0
`define CLKC_RST_LP2_EN       1'b1
`define CLKC_RST_STOP3_EN     1'b1
`define CLKC_RST_BYTE_COUNT   6'h0d
`define CLKC_RST_SLEW         2'h1
`define CLKC_RST_SREF_STOP    7'h00
`define CLKC_RST_VOUT         3'h5
`define CLKC_RST_SLEW_BC      8'h00
`define CLKC_SLEW_HIZ         2'h0

`endif

// File: hw/clkc_pkg.sv
// types shared by the control bank and the test-mode latch
// assumes nothing beyond a SystemVerilog compiler
package clkc_pkg;

   typedef enum logic [2:0] {
      CLKC_NORMAL = 3'b001,
      CLKC_HWTEST = 3'b010,
      CLKC_SWTEST = 3'b100
   } clkc_tmode_type;

   typedef logic [7:0] clkc_addr_type;
   typedef logic [7:0] clkc_byte_type;

endpackage

// File: hw/clkc_test_if.sv
// carrier between the register bank and the test-mode latch
// assumes all signals on the bank clock, pin levels already synchronised
`timescale 1ns/10ps
interface clkc_test_if;
   logic pg;
   logic strap;
   logic tm_pin;
   logic sw_entry;
   logic sw_sel;
   logic active;
   logic drive;

   modport bank (output pg, strap, tm_pin, sw_entry, sw_sel, input active, drive);
   modport latch (input pg, strap, tm_pin, sw_entry, sw_sel, output active, drive);
endinterface

// File: hw/clkc_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk
`timescale 1ns/10ps
module clkc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,   // bank clock
   input  wire logic             rst,   // async reset, high
   input  wire logic [WIDTH-1:0] din,   // raw pin levels
   output logic      [WIDTH-1:0] dout   // synchronised levels
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } clkc_sync_type;

   clkc_sync_type s;
   clkc_sync_type next_s;

   always_comb begin
      next_s        = s;
      next_s.meta   = din;
      next_s.stable = s.meta;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.stable;
endmodule

// File: hw/clkc_test.sv
// test-mode entry latch: strap route on power-good rise, software route otherwise
// assumes synchronised inputs; only the async reset (power cycle) leaves test mode
`timescale 1ns/10ps
module clkc_test
   import clkc_pkg::*;
(
   input  wire logic clk,              // bank clock
   input  wire logic rst,              // async reset, high
   clkc_test_if.latch t                // strap, pins, software bits
);
   typedef struct packed {
      logic           pg_d;
      logic           strap_lat;
      clkc_tmode_type mode;
   } clkc_test_state_type;

   clkc_test_state_type s;
   clkc_test_state_type next_s;
   logic                pg_rise;

   assign pg_rise = t.pg & ~s.pg_d;

   always_comb begin
      next_s      = s;
      next_s.pg_d = t.pg;
      case (s.mode)
         CLKC_NORMAL: begin
            if (pg_rise) begin
               next_s.strap_lat = t.strap;
               if (t.strap) begin
                  next_s.mode = CLKC_HWTEST;
               end
            end else if (t.sw_entry && !s.strap_lat && s.pg_d) begin
               next_s.mode = CLKC_SWTEST;
            end
         end
         CLKC_HWTEST: next_s.mode = CLKC_HWTEST;
         CLKC_SWTEST: next_s.mode = CLKC_SWTEST;
         default:     next_s.mode = CLKC_NORMAL;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{pg_d: 1'b0, strap_lat: 1'b0, mode: CLKC_NORMAL};
      end else begin
         s <= next_s;
      end
   end

   assign t.active = (s.mode != CLKC_NORMAL);
   // live pin in hardware route, software bit only in software route
   assign t.drive  = (s.mode == CLKC_HWTEST) ? t.tm_pin :
                     (s.mode == CLKC_SWTEST) ? t.sw_sel : 1'b0;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence strap_rise_s;
      (s.mode == CLKC_NORMAL) && t.pg && !s.pg_d && t.strap;
   endsequence

   sequence sw_request_s;
      (s.mode == CLKC_NORMAL) && s.pg_d && t.pg && !s.strap_lat && t.sw_entry;
   endsequence

   a_hw_test_entry: assert property (strap_rise_s |=> s.mode == CLKC_HWTEST)
      else $error("strap at power-good rise did not enter test mode");
   a_hw_live_pin: assert property ((s.mode == CLKC_HWTEST) |-> t.drive == t.tm_pin)
      else $error("hardware test output does not follow live pin");
   a_sw_test_entry: assert property (sw_request_s |=> s.mode == CLKC_SWTEST)
      else $error("software entry bit did not enter test mode");
   a_sw_select_only: assert property ((s.mode == CLKC_SWTEST) |-> t.drive == t.sw_sel)
      else $error("software test output not chosen by select bit");
   a_test_one_shot: assert property ((s.mode != CLKC_NORMAL) |=> s.mode == $past(s.mode))
      else $error("test mode left without power cycle");
endmodule

// File: hw/clkc_regs.sv
// control bank bytes 11..21 of the clock generator plus test-mode control
// assumes a byte register port on CLK; pin inputs are asynchronous
//
// Contract
// - bits 3 and 2 of byte 11 keep the third and second processor pairs running in management low-power mode, the third only with debug port enabled; resets 0 and 1.
// - byte 11 bit 0 set (reset) stops the third processor pair while processor stop is asserted, clear leaves it free running.
// - byte 12 bits 5..0 hold a writable readback byte count resetting to 001101 with bits 7 and 6 reserved.
// - byte 13 holds two-bit slew codes for reference, fixed 27 MHz and spread 27 MHz outputs where 00 is high impedance and each resets to 01.
// - byte 17 bits 7,6,5,4,3,1 and byte 18 bit 6 each stop one serial-reference output while peripheral stop is asserted.
// - bytes 18 and 19 hold read-write three-bit output-voltage fields, msb first, defaulting to the 0.8V code.
// - hardware test mode is entered when power-good rises while the latched strap reads 1.
// - in hardware test mode the live test-mode pin chooses high impedance or divided reference.
// - with the strap 0 at power-good rise, writing 1 to byte 9 bit 3 enters test mode; it resets to 0.
// - in software test mode only byte 9 bit 4 chooses divided reference (1) or high impedance (0).
// - test mode once entered stays until power is cycled, clearing the entry bit does not leave it.
`timescale 1ns/10ps
`include "clkc_cfg.svh"
module clkc_regs (
   input  wire logic                 CLK,              // 250 MHz bank clock
   input  wire logic                 SYS_RST,          // async reset, high (power cycle)
   input  wire clkc_pkg::clkc_addr_type ADDR,          // register byte address
   input  wire clkc_pkg::clkc_byte_type WDATA,         // write data
   input  wire logic                 WR,               // write strobe
   input  wire logic                 RD,               // read strobe
   output clkc_pkg::clkc_byte_type   RDATA,            // read data, cycle after RD
   input  wire logic                 POWER_GOOD,       // power-good pin
   input  wire logic                 TEST_SEL_STRAP,   // test-select strap pin
   input  wire logic                 TEST_MODE_PIN,    // live test-mode pin
   input  wire logic                 CPU_STOP_N,       // processor stop pin, low
   input  wire logic                 PCI_STOP_N,       // peripheral stop pin, low
   input  wire logic                 MGMT_LOWPWR_MODE, // management low-power mode
   input  wire logic                 DEBUG_PORT_ENABLE,// debug port enable
   output logic                      THIRD_PAIR_RUN,   // third processor pair runs
   output logic                      SECOND_PAIR_RUN,  // second processor pair runs
   output logic [6:0]                SERIAL_REF_RUN,   // serial-reference outputs run
   output logic [5:0]                BYTE_COUNT,       // readback byte count
   output logic [1:0]                SLEW_REF,         // reference slew code
   output logic [1:0]                SLEW_FIX27,       // fixed 27 MHz slew code
   output logic [1:0]                SLEW_SS27,        // spread 27 MHz slew code
   output logic [2:0]                SE_OUT_HIZ,       // ref, fix27, ss27 in high-z
   output logic [2:0]                VOUT_SRC,         // serial-ref group voltage
   output logic [2:0]                VOUT_S2A,         // alt serial-ref voltage
   output logic [2:0]                VOUT_LCD,         // display spread voltage
   output logic [2:0]                VOUT_DOT,         // dot clock group voltage
   output logic [7:0]                SLEW_B,           // byte 20 contents
   output logic [7:0]                SLEW_C,           // byte 21 contents
   output logic                      TEST_ACTIVE,      // test mode latched
   output logic                      TEST_REF_DRIVE,   // outputs carry divided ref
   output logic                      TEST_HIZ          // outputs in high-z for test
);
   import clkc_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic         sw_entry;
      logic         sw_sel;
      logic         lp3_en;
      logic         lp2_en;
      logic         stop3_en;
      logic [5:0]   bc;
      logic [1:0]   slew_ref;
      logic [1:0]   slew_fix;
      logic [1:0]   slew_ss;
      logic [6:0]   sref_stop;
      logic [2:0]   vout_src;
      logic [2:0]   vout_s2a;
      logic [2:0]   vout_lcd;
      logic [2:0]   vout_dot;
      logic [7:0]   slew_b;
      logic [7:0]   slew_c;
      logic         third_run;
      logic         second_run;
      logic [6:0]   sref_run;
      logic [2:0]   se_hiz;
      logic         test_active;
      logic         test_drive;
      logic         test_hiz;
      clkc_byte_type rdata;
   } clkc_bank_type;

   localparam clkc_bank_type BANK_RST = '{
      sw_entry: 1'b0, sw_sel: 1'b0,
      lp3_en: `CLKC_RST_LP3_EN, lp2_en: `CLKC_RST_LP2_EN, stop3_en: `CLKC_RST_STOP3_EN,
      bc: `CLKC_RST_BYTE_COUNT,
      slew_ref: `CLKC_RST_SLEW, slew_fix: `CLKC_RST_SLEW, slew_ss: `CLKC_RST_SLEW,
      sref_stop: `CLKC_RST_SREF_STOP,
      vout_src: `CLKC_RST_VOUT, vout_s2a: `CLKC_RST_VOUT,
      vout_lcd: `CLKC_RST_VOUT, vout_dot: `CLKC_RST_VOUT,
      slew_b: `CLKC_RST_SLEW_BC, slew_c: `CLKC_RST_SLEW_BC,
      third_run: 1'b1, second_run: 1'b1, sref_run: 7'h7f, se_hiz: 3'h0,
      test_active: 1'b0, test_drive: 1'b0, test_hiz: 1'b0,
      rdata: 8'h00
   };

   clkc_bank_type r;
   clkc_bank_type next_r;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic hit(input clkc_addr_type a, input clkc_addr_type off);
      hit = (a == off);
   endfunction

   function automatic logic is_hiz(input logic [1:0] code);
      is_hiz = (code == `CLKC_SLEW_HIZ);
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [6:0] pins_s;
   logic       pg_s;
   logic       strap_s;
   logic       tm_s;
   logic       cpu_stop;
   logic       pci_stop;
   logic       mgmt_s;
   logic       dbg_s;

   clkc_sync #(.WIDTH(7)) u_sync (
      .clk  (CLK),
      .rst  (SYS_RST),
      .din  ({POWER_GOOD, TEST_SEL_STRAP, TEST_MODE_PIN, CPU_STOP_N, PCI_STOP_N,
              MGMT_LOWPWR_MODE, DEBUG_PORT_ENABLE}),
      .dout (pins_s)
   );

   assign pg_s     = pins_s[6];
   assign strap_s  = pins_s[5];
   assign tm_s     = pins_s[4];
   assign cpu_stop = ~pins_s[3];
   assign pci_stop = ~pins_s[2];
   assign mgmt_s   = pins_s[1];
   assign dbg_s    = pins_s[0];

   // ****************************************
   // test-mode latch
   // ****************************************
   clkc_test_if ti ();

   assign ti.pg       = pg_s;
   assign ti.strap    = strap_s;
   assign ti.tm_pin   = tm_s;
   assign ti.sw_entry = r.sw_entry;
   assign ti.sw_sel   = r.sw_sel;

   clkc_test u_test (
      .clk (CLK),
      .rst (SYS_RST),
      .t   (ti.latch)
   );

   // ****************************************
   // read view
   // ****************************************
   clkc_byte_type rd_view;
   logic [6:0]    sref_mask;

   assign sref_mask = r.sref_stop & {7{pci_stop}};

   always_comb begin
      rd_view = 8'h00;
      if (hit(ADDR, `CLKC_OFF_TEST_CTRL)) begin
         rd_view[`CLKC_POS_SW_SEL]   = r.sw_sel;
         rd_view[`CLKC_POS_SW_ENTRY] = r.sw_entry;
      end else if (hit(ADDR, `CLKC_OFF_MGMT_CPU)) begin
         rd_view[`CLKC_POS_LP3_EN]   = r.lp3_en;
         rd_view[`CLKC_POS_LP2_EN]   = r.lp2_en;
         rd_view[`CLKC_POS_STOP3_EN] = r.stop3_en;
      end else if (hit(ADDR, `CLKC_OFF_BYTE_COUNT)) begin
         rd_view[5:0] = r.bc;
      end else if (hit(ADDR, `CLKC_OFF_SLEW_A)) begin
         rd_view[`CLKC_POS_SLEW_REF+:2] = r.slew_ref;
         rd_view[`CLKC_POS_SLEW_FIX+:2] = r.slew_fix;
         rd_view[`CLKC_POS_SLEW_SS+:2]  = r.slew_ss;
      end else if (hit(ADDR, `CLKC_OFF_SREF_STOP)) begin
         rd_view = {r.sref_stop[5:1], 1'b0, r.sref_stop[0], 1'b0};
      end else if (hit(ADDR, `CLKC_OFF_DIFF_A)) begin
         rd_view[`CLKC_POS_SREF11_STOP]  = r.sref_stop[6];
         rd_view[`CLKC_POS_VOUT_SRC+:3] = r.vout_src;
         rd_view[`CLKC_POS_VOUT_S2A+:3] = r.vout_s2a;
      end else if (hit(ADDR, `CLKC_OFF_DIFF_B)) begin
         rd_view[`CLKC_POS_VOUT_LCD+:3] = r.vout_lcd;
         rd_view[`CLKC_POS_VOUT_DOT+:3] = r.vout_dot;
      end else if (hit(ADDR, `CLKC_OFF_SLEW_B)) begin
         rd_view = r.slew_b;
      end else if (hit(ADDR, `CLKC_OFF_SLEW_C)) begin
         rd_view = r.slew_c;
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_r = r;
      if (WR) begin
         if (hit(ADDR, `CLKC_OFF_TEST_CTRL)) begin
            next_r.sw_sel   = WDATA[`CLKC_POS_SW_SEL];
            next_r.sw_entry = WDATA[`CLKC_POS_SW_ENTRY];
         end
         if (hit(ADDR, `CLKC_OFF_MGMT_CPU)) begin
            next_r.lp3_en   = WDATA[`CLKC_POS_LP3_EN];
            next_r.lp2_en   = WDATA[`CLKC_POS_LP2_EN];
            next_r.stop3_en = WDATA[`CLKC_POS_STOP3_EN];
         end
         if (hit(ADDR, `CLKC_OFF_BYTE_COUNT)) begin
            next_r.bc = WDATA[5:0];
         end
         if (hit(ADDR, `CLKC_OFF_SLEW_A)) begin
            next_r.slew_ref = WDATA[`CLKC_POS_SLEW_REF+:2];
            next_r.slew_fix = WDATA[`CLKC_POS_SLEW_FIX+:2];
            next_r.slew_ss  = WDATA[`CLKC_POS_SLEW_SS+:2];
         end
         if (hit(ADDR, `CLKC_OFF_SREF_STOP)) begin
            next_r.sref_stop[5:0] = {WDATA[7:3], WDATA[1]};
         end
         if (hit(ADDR, `CLKC_OFF_DIFF_A)) begin
            next_r.sref_stop[6] = WDATA[`CLKC_POS_SREF11_STOP];
            next_r.vout_src     = WDATA[`CLKC_POS_VOUT_SRC+:3];
            next_r.vout_s2a     = WDATA[`CLKC_POS_VOUT_S2A+:3];
         end
         if (hit(ADDR, `CLKC_OFF_DIFF_B)) begin
            next_r.vout_lcd = WDATA[`CLKC_POS_VOUT_LCD+:3];
            next_r.vout_dot = WDATA[`CLKC_POS_VOUT_DOT+:3];
         end
         if (hit(ADDR, `CLKC_OFF_SLEW_B)) begin
            next_r.slew_b = WDATA;
         end
         if (hit(ADDR, `CLKC_OFF_SLEW_C)) begin
            next_r.slew_c = WDATA;
         end
      end
      // clock gating from stop pins and low-power mode, then high-z, test-mode and read-data registers
      next_r.third_run  = !(cpu_stop && r.stop3_en) &&
                          (!mgmt_s || (r.lp3_en && dbg_s));
      next_r.second_run = !mgmt_s || r.lp2_en;
      next_r.sref_run   = ~sref_mask;
      next_r.se_hiz     = {is_hiz(r.slew_ref), is_hiz(r.slew_fix), is_hiz(r.slew_ss)};
      next_r.test_active = ti.active;
      next_r.test_drive  = ti.active && ti.drive;
      next_r.test_hiz    = ti.active && !ti.drive;
      next_r.rdata       = RD ? rd_view : 8'h00;
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         r <= BANK_RST;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign RDATA           = r.rdata;
   assign THIRD_PAIR_RUN  = r.third_run;
   assign SECOND_PAIR_RUN = r.second_run;
   assign SERIAL_REF_RUN  = r.sref_run;
   assign BYTE_COUNT      = r.bc;
   assign SLEW_REF        = r.slew_ref;
   assign SLEW_FIX27      = r.slew_fix;
   assign SLEW_SS27       = r.slew_ss;
   assign SE_OUT_HIZ      = r.se_hiz;
   assign VOUT_SRC        = r.vout_src;
   assign VOUT_S2A        = r.vout_s2a;
   assign VOUT_LCD        = r.vout_lcd;
   assign VOUT_DOT        = r.vout_dot;
   assign SLEW_B          = r.slew_b;
   assign SLEW_C          = r.slew_c;
   assign TEST_ACTIVE     = r.test_active;
   assign TEST_REF_DRIVE  = r.test_drive;
   assign TEST_HIZ        = r.test_hiz;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   sequence bc_read_s;
      RD && hit(ADDR, `CLKC_OFF_BYTE_COUNT);
   endsequence

   sequence diff_a_write_s;
      WR && hit(ADDR, `CLKC_OFF_DIFF_A);
   endsequence

   a_lowpwr_debug_gate: assert property ((mgmt_s && !dbg_s) |=> !THIRD_PAIR_RUN)
      else $error("third pair runs in low-power mode without debug port");
   a_third_pair_stop: assert property ((cpu_stop && r.stop3_en) |=> !THIRD_PAIR_RUN)
      else $error("third pair not stopped by processor stop");
   a_third_pair_free: assert property ((!r.stop3_en && !mgmt_s) |=> THIRD_PAIR_RUN)
      else $error("free-running third pair stopped");
   a_byte_count_read: assert property (bc_read_s |=> RDATA == {2'b00, $past(r.bc)})
      else $error("byte count readback wrong");
   a_slew_code_hiz: assert property (1'b1 |=> SE_OUT_HIZ[2] == ($past(r.slew_ref) == 2'h0))
      else $error("reference high-z does not follow slew code");
   a_sref_stop_map: assert property (1'b1 |=> SERIAL_REF_RUN == ~$past(sref_mask))
      else $error("serial-reference run does not follow stop bits");
   a_vout_write_path: assert property (diff_a_write_s |=> VOUT_SRC == $past(WDATA[5:3]))
      else $error("voltage select write not reflected");
   a_reserved_zero: assert property (RD && hit(ADDR, `CLKC_OFF_RSVD) |=> RDATA == 8'h00)
      else $error("reserved byte read nonzero");
   a_test_output_sticky: assert property (TEST_ACTIVE |=> TEST_ACTIVE)
      else $error("test mode dropped without reset");
endmodule

// File: tb/clkc_board.sv
// board-side model: power-good sequencing and the test-select strap
// assumes rst is the power cycle; strap_req set before rst falls
`timescale 1ns/10ps
module clkc_board #(
   parameter int PG_DELAY = 8
) (
   input  wire logic clk,        // bench clock
   input  wire logic rst,        // power cycle, high
   input  wire logic strap_req,  // strap level fitted on the board
   output logic      pg,         // power-good to the block
   output logic      strap       // test-select strap to the block
);
   int cnt;

   // ****************************************
   // power-good rises after a delay, strap held steady across it
   // ****************************************
   assign strap = strap_req;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         pg  <= 1'b0;
      end else if (cnt < PG_DELAY) begin
         cnt <= cnt + 1;
      end else begin
         pg  <= 1'b1;
      end
   end
endmodule

// File: tb/testbench.sv
// self-checking bench of the control bank and the test-mode latch
// assumes clkc_regs, clkc_board and the package are compiled first
`timescale 1ns/10ps
module testbench;
   import clkc_pkg::*;
   logic          CLK, SYS_RST, WR, RD, POWER_GOOD, TEST_SEL_STRAP, TEST_MODE_PIN;
   logic          CPU_STOP_N, PCI_STOP_N, MGMT_LOWPWR_MODE, DEBUG_PORT_ENABLE;
   logic          THIRD_PAIR_RUN, SECOND_PAIR_RUN, TEST_ACTIVE, TEST_REF_DRIVE, TEST_HIZ;
   logic          strap_req, rd_q;
   clkc_addr_type ADDR;
   clkc_byte_type WDATA, RDATA, d, e, wv[10], exp_q[$];
   logic [6:0]    SERIAL_REF_RUN;
   logic [5:0]    BYTE_COUNT;
   logic [1:0]    SLEW_REF, SLEW_FIX27, SLEW_SS27;
   logic [2:0]    SE_OUT_HIZ, VOUT_SRC, VOUT_S2A, VOUT_LCD, VOUT_DOT;
   logic [7:0]    SLEW_B, SLEW_C;
   int            n_fail, checks_done, seed;
   localparam clkc_byte_type ADR[10]  = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13,
                                          8'h14, 8'h15, 8'h0f};
   localparam clkc_byte_type RSTV[10] = '{8'h05, 8'h0d, 8'h54, 8'h00, 8'h00, 8'h2d, 8'hb4,
                                          8'h00, 8'h00, 8'h00};
   localparam clkc_byte_type MSK[10]  = '{8'h0d, 8'h3f, 8'hfc, 8'h00, 8'hfa, 8'h7f, 8'hfc,
                                          8'hff, 8'hff, 8'h00};

   clkc_regs i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .POWER_GOOD(POWER_GOOD), .TEST_SEL_STRAP(TEST_SEL_STRAP),
      .TEST_MODE_PIN(TEST_MODE_PIN), .CPU_STOP_N(CPU_STOP_N), .PCI_STOP_N(PCI_STOP_N),
      .MGMT_LOWPWR_MODE(MGMT_LOWPWR_MODE), .DEBUG_PORT_ENABLE(DEBUG_PORT_ENABLE),
      .THIRD_PAIR_RUN(THIRD_PAIR_RUN), .SECOND_PAIR_RUN(SECOND_PAIR_RUN),
      .SERIAL_REF_RUN(SERIAL_REF_RUN), .BYTE_COUNT(BYTE_COUNT), .SLEW_REF(SLEW_REF),
      .SLEW_FIX27(SLEW_FIX27), .SLEW_SS27(SLEW_SS27), .SE_OUT_HIZ(SE_OUT_HIZ),
      .VOUT_SRC(VOUT_SRC), .VOUT_S2A(VOUT_S2A), .VOUT_LCD(VOUT_LCD), .VOUT_DOT(VOUT_DOT),
      .SLEW_B(SLEW_B), .SLEW_C(SLEW_C), .TEST_ACTIVE(TEST_ACTIVE),
      .TEST_REF_DRIVE(TEST_REF_DRIVE), .TEST_HIZ(TEST_HIZ));
   clkc_board #(.PG_DELAY(8)) i_board (.clk(CLK), .rst(SYS_RST), .strap_req(strap_req),
      .pg(POWER_GOOD), .strap(TEST_SEL_STRAP));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wr(input clkc_addr_type a, input clkc_byte_type v);
      @(posedge CLK);
      ADDR <= a; WDATA <= v; WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input clkc_addr_type a, input clkc_byte_type v);
      @(posedge CLK);
      ADDR <= a; RD <= 1'b1; exp_q.push_back(v);
      @(posedge CLK);
      RD <= 1'b0;
   endtask
   task automatic settle();
      repeat (6) @(posedge CLK);
   endtask
   task automatic do_reset();
      @(posedge CLK);
      SYS_RST <= 1'b1;
      repeat (12) @(posedge CLK);
      SYS_RST <= 1'b0;
      repeat (20) @(posedge CLK);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ****************************************
   // clock, read monitor, watchdog
   // ****************************************
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      if (rd_q) chk(RDATA, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
      rd_q <= RD;
   end
   initial begin
      repeat (20000) @(posedge CLK);
      n_fail++;
      test_done();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {WR, RD, ADDR, WDATA, TEST_MODE_PIN, MGMT_LOWPWR_MODE, DEBUG_PORT_ENABLE} = '0;
      {CPU_STOP_N, PCI_STOP_N, SYS_RST} = '1;
      {strap_req, rd_q, n_fail, checks_done} = '0;
      seed = 32'h78a3;
      do_reset();
      rd(8'h09, 8'h00);
      for (int i = 0; i < 10; i++) rd(ADR[i], RSTV[i]);
      for (int i = 0; i < 10; i++) begin
         wv[i] = $random(seed);
         wr(ADR[i], wv[i]);
         rd(ADR[i], wv[i] & MSK[i]);
      end
      chk({2'h0, BYTE_COUNT}, {2'h0, wv[1][5:0]});
      chk({2'h0, VOUT_SRC, VOUT_S2A}, {2'h0, wv[5][5:0]});
      chk({2'h0, VOUT_LCD, VOUT_DOT}, {2'h0, wv[6][7:2]});
      chk(SLEW_B, wv[7]);
      chk(SLEW_C, wv[8]);
      $display("register bank test done");
      CPU_STOP_N <= 1'b0;
      for (int b = 0; b < 2; b++) begin
         wr(8'h0b, 8'(b));
         settle();
         chk(8'(THIRD_PAIR_RUN), 8'(b == 0));
      end
      CPU_STOP_N <= 1'b1;
      MGMT_LOWPWR_MODE <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         DEBUG_PORT_ENABLE <= i[2];
         wr(8'h0b, {4'h0, i[0], i[1], 2'h0});
         settle();
         chk(8'(THIRD_PAIR_RUN), 8'(i[0] & i[2]));
         chk(8'(SECOND_PAIR_RUN), 8'(i[1]));
      end
      $display("processor pair test done");
      PCI_STOP_N <= 1'b0;
      d = $random(seed);
      e = $random(seed);
      wr(8'h11, d);
      wr(8'h12, e);
      settle();
      chk({1'b0, SERIAL_REF_RUN}, {1'b0, ~{e[6], d[7:3], d[1]}});
      PCI_STOP_N <= 1'b1;
      settle();
      chk({1'b0, SERIAL_REF_RUN}, 8'h7f);
      for (int c = 0; c < 4; c++) begin
         wr(8'h0d, {c[1:0], c[1:0], c[1:0], 2'h0});
         settle();
         chk({2'h0, SLEW_REF, SLEW_FIX27, SLEW_SS27}, {2'h0, c[1:0], c[1:0], c[1:0]});
         chk({5'h0, SE_OUT_HIZ}, (c == 0) ? 8'h07 : 8'h00);
      end
      $display("stop and slew test done");
      chk(8'(TEST_ACTIVE), 8'h00);
      TEST_MODE_PIN <= 1'b1;
      wr(8'h09, 8'h08);
      settle();
      chk({5'h0, TEST_ACTIVE, TEST_REF_DRIVE, TEST_HIZ}, 8'h05);
      wr(8'h09, 8'h18);
      settle();
      chk({5'h0, TEST_ACTIVE, TEST_REF_DRIVE, TEST_HIZ}, 8'h06);
      wr(8'h09, 8'h00);
      settle();
      chk({5'h0, TEST_ACTIVE, TEST_REF_DRIVE, TEST_HIZ}, 8'h05);
      $display("software test mode done");
      strap_req <= 1'b1;
      do_reset();
      wr(8'h09, 8'h10);
      for (int p = 0; p < 2; p++) begin
         TEST_MODE_PIN <= p[0];
         settle();
         chk({5'h0, TEST_ACTIVE, TEST_REF_DRIVE, TEST_HIZ}, p ? 8'h06 : 8'h05);
      end
      $display("hardware test mode done");
      test_done();
   end
endmodule
